// File: hdl/nba_decoder.sv
// Purpose: Decode and execute four instruction words of a 4-bit core
// Assumes: instr_valid, instr_word, mem_nibble and conv_done come from mclk logic
// Notes: One word per cycle; a skipped word is not executed but sets the skip interrupt status bit
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Immediate add puts accumulator plus n into accumulator in one cycle
// - Immediate add never changes the carry flag
// - Immediate add skips the next word when no overflow occurred
// - Mode bit 3 low starts conversion, high starts comparator
// - Add memory puts accumulator plus memory nibble into accumulator, carry kept
// - Add memory with carry stores sum and loads carry out
module nba_decoder
#(
  parameter logic [9:0] OPC_ADD_MEM_CARRY = nba_pkg::OPC_ADD_MEM_CARRY_DEF
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [3:0] mem_nibble,
  input wire logic conv_done,
  output logic [3:0] acc,
  output logic carry_flag,
  output logic skip_pending,
  output logic conversion_done_flag,
  output logic conv_start,
  output logic comp_start,
  output logic irq
);
  logic [3:0] converter_control_reg;
  logic [nba_pkg::IRQ_W-1:0] irq_status;
  logic [nba_pkg::IRQ_W-1:0] irq_mask;
  logic exec;
  logic is_add_imm;
  logic is_start;
  logic is_add_mem;
  logic is_add_memc;
  logic apb_wr;
  logic rd_setup;
  logic wr_ctrl;
  logic wr_acc;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic addr_ok;
  logic [nba_pkg::IRQ_W-1:0] events;
  logic [31:0] next_prdata;

  nba_add_if add_bus ();

  nba_nibble_adder u_adder
  (
    .bus(add_bus)
  );

  // ==========================================================
  // Decode
  // A word arriving while a skip is pending is consumed and ignored
  assign exec = instr_valid && !skip_pending;
  assign is_add_imm = exec && (instr_word[9:4] == nba_pkg::OPC_ADD_IMM_HI);
  assign is_start = exec && (instr_word == nba_pkg::OPC_START_CONV);
  assign is_add_mem = exec && (instr_word == nba_pkg::OPC_ADD_MEM);
  assign is_add_memc = exec && (instr_word == OPC_ADD_MEM_CARRY);

  // ==========================================================
  // Adder operands
  // One shared adder serves all three add words
  always_comb
  begin
    add_bus.op_a = acc;
    add_bus.op_b = mem_nibble;
    add_bus.cin = 1'b0;
    if (is_add_imm)
    begin
      add_bus.op_b = instr_word[3:0];
    end
    else if (is_add_memc)
    begin
      add_bus.cin = carry_flag;
    end
  end

  // ==========================================================
  // Bus decode
  assign apb_wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // Zero wait states: every register answers in its first access cycle
  assign pready = 1'b1;
  assign addr_ok = (paddr == nba_pkg::ADDR_CTRL) || (paddr == nba_pkg::ADDR_ACC)
    || (paddr == nba_pkg::ADDR_IRQ_STATUS) || (paddr == nba_pkg::ADDR_IRQ_MASK)
    || (paddr == nba_pkg::ADDR_FLAGS);
  assign pslverr = psel && penable && !addr_ok;

  // ==========================================================
  // Write strobes
  // Taken only at the access edge, so a setup cycle alone changes nothing
  assign wr_ctrl = apb_wr && (paddr == nba_pkg::ADDR_CTRL);
  assign wr_acc = apb_wr && (paddr == nba_pkg::ADDR_ACC);
  assign wr_irq_status = apb_wr && (paddr == nba_pkg::ADDR_IRQ_STATUS);
  assign wr_irq_mask = apb_wr && (paddr == nba_pkg::ADDR_IRQ_MASK);

  // ==========================================================
  // Accumulator
  // Instruction execution wins over a bus write in the same cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      acc <= nba_pkg::RST_ACC;
    end
    else if (is_add_imm || is_add_mem || is_add_memc)
    begin
      acc <= add_bus.sum;
    end
    else if (wr_acc)
    begin
      acc <= pwdata[3:0];
    end
  end

  // ==========================================================
  // Carry flag
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      carry_flag <= nba_pkg::RST_CARRY;
    end
    else if (is_add_memc)
    begin
      carry_flag <= add_bus.cout;
    end
    else if (is_add_imm || is_add_mem)
    begin
      carry_flag <= carry_flag;
    end
    else if (wr_acc)
    begin
      carry_flag <= pwdata[nba_pkg::ACC_CARRY_BIT];
    end
  end

  // ==========================================================
  // Skip
  // Only a valid word clears it, so idle cycles keep the skip armed
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      skip_pending <= 1'b0;
    end
    else if (instr_valid && skip_pending)
    begin
      skip_pending <= 1'b0;
    end
    else if (is_add_imm)
    begin
      skip_pending <= !add_bus.cout;
    end
  end

  // ==========================================================
  // Converter start
  // Registered so the converter sees a clean one-cycle strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conv_start <= 1'b0;
      comp_start <= 1'b0;
    end
    else
    begin
      conv_start <= is_start && !converter_control_reg[nba_pkg::MODE_BIT];
      comp_start <= is_start && converter_control_reg[nba_pkg::MODE_BIT];
    end
  end

  // ==========================================================
  // Conversion done flag
  // Completion arriving with the start word sets the flag: set wins
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conversion_done_flag <= 1'b0;
    end
    else if (conv_done)
    begin
      conversion_done_flag <= 1'b1;
    end
    else if (is_start)
    begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Control register
  // Only the mode bit is decoded; the other bits are kept for software
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      converter_control_reg <= nba_pkg::RST_CTRL;
    end
    else if (wr_ctrl)
    begin
      converter_control_reg <= pwdata[3:0];
    end
  end

  // ==========================================================
  // Interrupts
  always_comb
  begin
    events = '0;
    events[nba_pkg::IRQ_CONV_DONE] = conv_done;
    events[nba_pkg::IRQ_OVERFLOW] = is_add_imm && add_bus.cout;
    events[nba_pkg::IRQ_SKIP] = instr_valid && skip_pending;
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_status <= nba_pkg::RST_IRQ;
    end
    else if (wr_irq_status)
    begin
      irq_status <= (irq_status & ~pwdata[nba_pkg::IRQ_W-1:0]) | events;
    end
    else
    begin
      irq_status <= irq_status | events;
    end
  end

  // ==========================================================
  // Interrupt mask
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_mask <= nba_pkg::RST_IRQ;
    end
    else if (wr_irq_mask)
    begin
      irq_mask <= pwdata[nba_pkg::IRQ_W-1:0];
    end
  end

  // Level only: masking a pending bit drops the output at once
  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Read data
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      nba_pkg::ADDR_CTRL: next_prdata[3:0] = converter_control_reg;
      nba_pkg::ADDR_ACC: next_prdata[4:0] = {carry_flag, acc};
      nba_pkg::ADDR_IRQ_STATUS: next_prdata[nba_pkg::IRQ_W-1:0] = irq_status;
      nba_pkg::ADDR_IRQ_MASK: next_prdata[nba_pkg::IRQ_W-1:0] = irq_mask;
      nba_pkg::ADDR_FLAGS:
      begin
        next_prdata[nba_pkg::FLAG_DONE_BIT] = conversion_done_flag;
        next_prdata[nba_pkg::FLAG_SKIP_BIT] = skip_pending;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Registered in the setup cycle so data stands during the access phase
  // A register updated at the setup edge is read with its older value
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata <= next_prdata;
    end
  end
endmodule : nba_decoder
`default_nettype wire

// File: hdl/nba_pkg.sv
// Purpose: Shared constants for the nibble add and converter start decoder
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Opcodes are 10-bit instruction words
package nba_pkg;
  // ==========================================================
  // Instruction words
  localparam logic [5:0] OPC_ADD_IMM_HI = 6'h06;
  localparam logic [9:0] OPC_START_CONV = 10'h29f;
  localparam logic [9:0] OPC_ADD_MEM = 10'h00a;
  localparam logic [9:0] OPC_ADD_MEM_CARRY_DEF = 10'h00b;
  localparam int MODE_BIT = 3;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;

  // ==========================================================
  // Fields and reset values
  localparam int ACC_CARRY_BIT = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_OVERFLOW = 1;
  localparam int IRQ_SKIP = 2;
  localparam int FLAG_DONE_BIT = 0;
  localparam int FLAG_SKIP_BIT = 1;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [3:0] RST_ACC = 4'h0;
  localparam logic RST_CARRY = 1'b0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
endpackage : nba_pkg

// File: hdl/nba_add_if.sv
// Purpose: Carrier between the decoder and its nibble adder
// Assumes: Single clock, purely combinational traffic
// Notes: Four-bit operands
`timescale 1ns/10ps
`default_nettype none
interface nba_add_if;
  logic [3:0] op_a;
  logic [3:0] op_b;
  logic cin;
  logic [3:0] sum;
  logic cout;
  modport user (output op_a, output op_b, output cin, input sum, input cout);
  modport adder (input op_a, input op_b, input cin, output sum, output cout);
endinterface : nba_add_if
`default_nettype wire

// File: hdl/nba_nibble_adder.sv
// Purpose: Four-bit adder with carry in and carry out
// Assumes: Operands settled within the cycle
// Notes: Sum wraps modulo 16
`timescale 1ns/10ps
`default_nettype none
module nba_nibble_adder
(
  nba_add_if.adder bus
);
  logic [4:0] total;

  // ==========================================================
  // Add
  assign total = {1'b0, bus.op_a} + {1'b0, bus.op_b} + {4'h0, bus.cin};
  assign bus.sum = total[3:0];
  assign bus.cout = total[4];
endmodule : nba_nibble_adder
`default_nettype wire

// File: verif/nba_checker.sv
// Purpose: Port assertions for nba_decoder
// Assumes: One mclk domain, sync reset
// Notes: Cycles with an APB write are left out, though an executing word wins over the write to acc
`timescale 1ns/10ps
`default_nettype none
module nba_checker
#(
  parameter logic [9:0] OPC_ADD_MEM_CARRY = nba_pkg::OPC_ADD_MEM_CARRY_DEF
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [3:0] mem_nibble,
  input wire logic conv_done,
  input wire logic [3:0] acc,
  input wire logic carry_flag,
  input wire logic skip_pending,
  input wire logic conversion_done_flag,
  input wire logic conv_start,
  input wire logic comp_start
);
  // ========
  // Helpers
  logic ex;
  logic st;
  logic [3:0] n;
  assign ex = instr_valid && !skip_pending && !(psel && penable && pwrite);
  assign st = ex && instr_word == nba_pkg::OPC_START_CONV;
  assign n = instr_word[3:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_imm; ex && instr_word[9:4] == nba_pkg::OPC_ADD_IMM_HI; endsequence
  sequence s_one; conv_start ^ comp_start; endsequence
  // ========
  // Properties
  property p_imm; s_imm |=> acc == $past(acc) + $past(n); endproperty
  a_imm: assert property (p_imm) else $error("imm sum");
  property p_imm_cy; s_imm |=> $stable(carry_flag); endproperty
  a_imm_cy: assert property (p_imm_cy) else $error("imm carry");
  property p_skip; s_imm |=> skip_pending == ({1'b0, $past(acc)} + $past(n) < 5'h10); endproperty
  a_skip: assert property (p_skip) else $error("skip set");
  property p_drop; instr_valid && skip_pending |=> !skip_pending; endproperty
  a_drop: assert property (p_drop) else $error("skip kept");
  property p_clr; st && !conv_done |=> !conversion_done_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_go; st |=> s_one; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_am; ex && instr_word == nba_pkg::OPC_ADD_MEM
    |=> acc == $past(acc) + $past(mem_nibble) && $stable(carry_flag); endproperty
  a_am: assert property (p_am) else $error("add mem");
  property p_amc; ex && instr_word == OPC_ADD_MEM_CARRY
    |=> {carry_flag, acc} == {1'b0, $past(acc)} + $past(mem_nibble) + $past(carry_flag);
  endproperty
  a_amc: assert property (p_amc) else $error("add carry");
endmodule : nba_checker
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for nba_decoder
// Assumes: Zero-wait APB slave, one mclk
// Notes: Integer model; words spaced by one idle cycle
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ========
  // Signals
  logic mclk, reset, psel, penable, pwrite, instr_valid, conv_done, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [9:0] instr_word, w;
  logic [3:0] mem_nibble, acc;
  logic carry_flag, skip_pending, conversion_done_flag, conv_start, comp_start, irq, re;
  int fail_count, checks_done, m_acc, m_cy, m_skip, m_done, m_st, m_mk, m_mode, m_cs, m_ps;
  int i;
  nba_decoder dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .mem_nibble(mem_nibble), .conv_done(conv_done), .acc(acc), .carry_flag(carry_flag),
    .skip_pending(skip_pending), .conversion_done_flag(conversion_done_flag),
    .conv_start(conv_start), .comp_start(comp_start), .irq(irq));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    #2000000;
    fail_count++;
    print_verdict();
  end
  // ========
  // Tasks
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk_rd(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD %0t read %h want %h", $time, g, x);
    end
  endtask : chk_rd
  task chk_core;
    logic [9:0] x;
    checks_done++;
    x = {m_cs[0], m_ps[0], m_done[0], m_skip[0], m_cy[0], m_acc[3:0], (m_st & m_mk) != 0};
    if ({conv_start, comp_start, conversion_done_flag, skip_pending, carry_flag, acc, irq} !== x)
    begin
      fail_count++;
      $display("BAD %0t core want %h", $time, x);
    end
    m_cs = 0;
    m_ps = 0;
  endtask : chk_core
  // Holds the request up to 16 cycles for pready, so a slow answer still pairs up
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      fail_count++;
      print_verdict();
    end
    rv = prdata;
    re = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk_rd(rv, x);
    chk_rd({31'h0, re}, {31'h0, xe});
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      nba_pkg::ADDR_CTRL: m_mode = d[3];
      nba_pkg::ADDR_ACC:
      begin
        m_cy = d[4];
        m_acc = d[3:0];
      end
      nba_pkg::ADDR_IRQ_STATUS: m_st = m_st & ~d[2:0];
      nba_pkg::ADDR_IRQ_MASK: m_mk = d[2:0];
      default: ;
    endcase
    #1 chk_core();
  endtask : wr
  task pulse;
    @(posedge mclk);
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    m_done = 1;
    m_st = m_st | 1;
    #1 chk_core();
  endtask : pulse
  task exec(input logic [9:0] c, input logic [3:0] m);
    int s;
    @(posedge mclk);
    {instr_valid, instr_word, mem_nibble} <= {1'b1, c, m};
    @(posedge mclk);
    instr_valid <= 1'b0;
    if (m_skip)
      {m_skip, m_st} = {32'd0, m_st | 4};
    else if (c[9:4] == nba_pkg::OPC_ADD_IMM_HI)
    begin
      s = m_acc + c[3:0];
      {m_acc, m_skip} = {s % 16, int'(s < 16)};
      if (s > 15)
        m_st = m_st | 2;
    end
    else if (c == nba_pkg::OPC_START_CONV)
      {m_done, m_cs, m_ps} = {32'd0, int'(!m_mode), m_mode};
    else if (c == nba_pkg::OPC_ADD_MEM)
      m_acc = (m_acc + m) % 16;
    else if (c == nba_pkg::OPC_ADD_MEM_CARRY_DEF)
    begin
      s = m_acc + m + m_cy;
      {m_acc, m_cy} = {s % 16, s / 16};
    end
    #1 chk_core();
  endtask : exec
  // ========
  // Main sequence
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, instr_valid, instr_word} = '0;
    {mem_nibble, conv_done} = 5'h00;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    void'($urandom(32'h1c9f));
    for (i = 0; i <= 20; i += 4)
      rd(8'(i), 32'h0, i == 20);
    $display("test reset and map done");
    wr(nba_pkg::ADDR_IRQ_MASK, 32'h7);
    wr(nba_pkg::ADDR_ACC, 32'h1f);
    exec(nba_pkg::OPC_ADD_MEM_CARRY_DEF, 4'hf);
    exec({nba_pkg::OPC_ADD_IMM_HI, 4'h1}, 4'h0);
    exec({nba_pkg::OPC_ADD_IMM_HI, 4'h0}, 4'h0);
    exec(nba_pkg::OPC_ADD_MEM, 4'h5);
    for (i = 0; i < 2; i++)
    begin
      wr(nba_pkg::ADDR_CTRL, 32'(i * 8));
      pulse();
      exec(nba_pkg::OPC_START_CONV, 4'h0);
    end
    rd(nba_pkg::ADDR_IRQ_STATUS, 32'(m_st), 1'b0);
    wr(nba_pkg::ADDR_IRQ_STATUS, 32'h7);
    $display("test directed done");
    for (i = 0; i < 400; i++)
    begin
      case ($urandom % 5)
        0: w = {nba_pkg::OPC_ADD_IMM_HI, 4'($urandom)};
        1: w = nba_pkg::OPC_START_CONV;
        2: w = nba_pkg::OPC_ADD_MEM;
        3: w = nba_pkg::OPC_ADD_MEM_CARRY_DEF;
        default: w = 10'($urandom);
      endcase
      exec(w, 4'($urandom));
      if ($urandom % 6 == 0)
        pulse();
      if (i % 50 == 0)
        wr(nba_pkg::ADDR_CTRL, $urandom);
      if (i % 70 == 0)
        wr(nba_pkg::ADDR_IRQ_MASK, $urandom);
    end
    rd(nba_pkg::ADDR_FLAGS, 32'({m_skip[0], m_done[0]}), 1'b0);
    $display("test random done");
    print_verdict();
  end
endmodule : tb_top
bind nba_decoder nba_checker #(.OPC_ADD_MEM_CARRY(OPC_ADD_MEM_CARRY)) chk_u (.mclk(mclk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .instr_valid(instr_valid),
  .instr_word(instr_word), .mem_nibble(mem_nibble), .conv_done(conv_done), .acc(acc),
  .carry_flag(carry_flag), .skip_pending(skip_pending), .conv_start(conv_start),
  .conversion_done_flag(conversion_done_flag), .comp_start(comp_start));
`default_nettype wire
